//--- ircc_cfg_pkg.sv
// constants, field layouts, reset values and types for the configuration access block
// assumes the host bus pins reach the device through the top module's synchronisers
//
// Operation
// - multiplexed modes decode from bus, blocks, select
// - low five bits address; top three match blocks
// - chip select high decodes nothing
// - block mismatch decodes nothing
// - multiplexed modes free two extra GPIO lines
// - enabled devices keep running in configuration state
// - key/index at offset 0, data at 1
// - power up in run state, ports inactive
// - entry byte opens index and data ports
// - load index before data port access
// - ten registers, data port follows index
// - access stays enabled until explicit exit; a hard reset also returns to run
// - exit byte closes ports, back to run
// - power-on defaults; hard reset clears three
// - defaults: option 02, control B 01, timeout 03
// - reserved bits ignore writes, read zero
// - bank 0 eight addresses, upper reserved zero
// - interrupt control at index 0, reserved bits
// - bit 0 sets interrupt output polarity
// - lock bit blocks writes, reads still work
// - lock cannot be cleared by software
package ircc_cfg_pkg;

  // host interface select encodings
  localparam logic [1:0] HS_MUX_STROBE = 2'h2;
  localparam logic [1:0] HS_MUX_ISA    = 2'h3;

  // access key bytes
  localparam logic [7:0] KEY_ENTER = 8'h55;
  localparam logic [7:0] KEY_EXIT  = 8'haa;

  // address layout inside the 32-byte block
  localparam int         ADDR_BLOCK_MSB = 7;
  localparam int         ADDR_BLOCK_LSB = 5;
  localparam int         ADDR_BANK_MSB  = 4;
  localparam int         ADDR_BANK_LSB  = 3;
  localparam logic [1:0] BANK_CONFIG    = 2'h0;
  localparam logic [2:0] OFS_KEY_INDEX  = 3'h0;
  localparam logic [2:0] OFS_DATA       = 3'h1;

  // configuration register file
  localparam int         NUM_CFG_REGS = 10;
  localparam logic [7:0] IDX_IRQ_CTRL = 8'h00;
  localparam logic [7:0] IDX_DMA_CTRL = 8'h01;
  localparam logic [7:0] IDX_PWR_CTRL = 8'h08;
  localparam logic [7:0] IDX_LAST     = 8'h09;

  // interrupt control fields
  localparam int IRQ_POL_BIT = 0;
  localparam int LOCK_BIT    = 2;

  // power-on defaults, listed from index 9 down to 0
  localparam logic [8*NUM_CFG_REGS-1:0] CFG_POR_DEFAULTS =
    {8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00};
  // writable bits, listed from index 9 down to 0
  localparam logic [8*NUM_CFG_REGS-1:0] CFG_WRITE_MASKS =
    {8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h11, 8'h3f, 8'h03, 8'h05};
  // registers that hard reset returns to zero
  localparam logic [NUM_CFG_REGS-1:0] CFG_HARD_CLEAR = 10'h103;

  // access state
  typedef enum logic [1:0] {
    ST_RUN    = 2'b01,
    ST_CONFIG = 2'b10
  } cfg_state_t;

endpackage : ircc_cfg_pkg

//--- cfg_reg_file.sv
// ten indexed configuration registers with power-on and hard-reset defaults
// assumes write strobe, index and data come from the access logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module cfg_reg_file #(
  parameter int NUM_REGS = ircc_cfg_pkg::NUM_CFG_REGS
) (
  input  wire logic                  clk_sys,
  input  wire logic                  porRst_n,
  input  wire logic                  hardReset,
  input  wire logic                  wrEn,
  input  wire logic [3:0]            wrIndex,
  input  wire logic [7:0]            wrData,
  output logic      [8*NUM_REGS-1:0] regsFlat
);

  // one byte lane per register; masks keep reserved bits at zero
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      localparam logic [7:0] POR  = ircc_cfg_pkg::CFG_POR_DEFAULTS[8*gi +: 8];
      localparam logic [7:0] MASK = ircc_cfg_pkg::CFG_WRITE_MASKS[8*gi +: 8];
      logic      [7:0] value;
      wire logic [7:0] stickyBits;
      wire logic [7:0] next_value;
      // lock bit only ever ORs in, software cannot clear it
      assign stickyBits = (gi == 0) ? (value & (8'h01 << ircc_cfg_pkg::LOCK_BIT))
                                    : 8'h00;
      assign next_value = (wrData & MASK) | stickyBits;
      // each lane owns its own flops so no two processes share a variable
      always_ff @(posedge clk_sys or negedge porRst_n) begin
        if (!porRst_n) begin
          value <= POR;
        end else if (hardReset && ircc_cfg_pkg::CFG_HARD_CLEAR[gi]) begin
          value <= 8'h00;
        end else if (wrEn && (wrIndex == 4'(gi))) begin
          value <= next_value;
        end
      end
      assign regsFlat[8*gi +: 8] = value;
    end
  endgenerate

  wire logic [7:0] irqCtrl;
  assign irqCtrl = regsFlat[7:0];

  // reserved interrupt-control bits never show a one
  property p_reserved_zero;
    @(posedge clk_sys) disable iff (!porRst_n)
    (irqCtrl & ~ircc_cfg_pkg::CFG_WRITE_MASKS[7:0]) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved interrupt control bit set");

  // lock survives every write until hard reset
  property p_lock_sticky;
    @(posedge clk_sys) disable iff (!porRst_n)
    (irqCtrl[ircc_cfg_pkg::LOCK_BIT] && !hardReset) |=> irqCtrl[ircc_cfg_pkg::LOCK_BIT];
  endproperty
  a_lock_sticky: assert property (p_lock_sticky)
    else $error("lock bit cleared without hard reset");

  // hard reset clears dma control but keeps infrared option
  property p_hard_clear;
    @(posedge clk_sys) disable iff (!porRst_n)
    hardReset |=> (regsFlat[15:8] == 8'h00) && $stable(regsFlat[23:16]);
  endproperty
  a_hard_clear: assert property (p_hard_clear)
    else $error("hard reset default wrong");

endmodule : cfg_reg_file
`default_nettype wire

//--- config_access_and_mux_decode.sv
// multiplexed address decode and configuration access state for the infrared controller
// assumes host pins are asynchronous to clk_sys and strobes last several clock periods
`timescale 1ns/100ps
`default_nettype none
module config_access_and_mux_decode (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       hardReset,
  input  wire logic [1:0] host_type_select,
  input  wire logic [2:0] block_select_pins,
  input  wire logic       chip_sel_n,
  input  wire logic       addrEnable,
  input  wire logic       addrStrobe,
  input  wire logic       readDirPin,
  input  wire logic       strobePin_n,
  input  wire logic [7:0] adIn,
  input  wire logic       irqRequest,
  output logic      [7:0] adOut,
  output logic            adOe,
  output logic            irqPin,
  output logic            extraGpioAvail,
  output logic            configActive,
  output logic            writeLocked
);

  // reset release through two flip-flops
  logic rstMeta_n;
  logic rstSync_n;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_n <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_n <= 1'b1;
      rstSync_n <= rstMeta_n;
    end
  end

  // all host pins are asynchronous: two flip-flops before any logic
  localparam int PIN_W = 19;
  wire  logic [PIN_W-1:0] pinRaw;
  logic       [PIN_W-1:0] pinMeta;
  logic       [PIN_W-1:0] pinSync;
  assign pinRaw = {hardReset, host_type_select, block_select_pins, chip_sel_n,
                   addrEnable, addrStrobe, readDirPin, strobePin_n, adIn};
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pinMeta <= 19'h01b00; // idle levels: selects and strobes inactive
      pinSync <= 19'h01b00;
    end else begin
      pinMeta <= pinRaw;
      pinSync <= pinMeta;
    end
  end

  // named copies of the synchronised pins
  wire logic       hardRstS;
  wire logic [1:0] hostTypeS;
  wire logic [2:0] blockSelS;
  wire logic       chipSelS_n;
  wire logic       addrEnableS;
  wire logic       addrStrobeS;
  wire logic       readDirS;
  wire logic       strobeS_n;
  wire logic [7:0] adS;
  assign hardRstS    = pinSync[18];
  assign hostTypeS   = pinSync[17:16];
  assign blockSelS   = pinSync[15:13];
  assign chipSelS_n  = pinSync[12];
  assign addrEnableS = pinSync[11];
  assign addrStrobeS = pinSync[10];
  assign readDirS    = pinSync[9];
  assign strobeS_n   = pinSync[8];
  assign adS         = pinSync[7:0];

  // mode decode; isa and reserved encodings decode nothing here
  wire logic muxMode;
  wire logic isaStrobes;
  assign muxMode    = (hostTypeS == ircc_cfg_pkg::HS_MUX_STROBE) ||
                      (hostTypeS == ircc_cfg_pkg::HS_MUX_ISA);
  assign isaStrobes = (hostTypeS == ircc_cfg_pkg::HS_MUX_ISA);

  // strobe decode: isa style uses separate read and write lows,
  // the other style uses a direction level qualified by a data strobe
  wire logic readNow;
  wire logic writeNow;
  assign readNow  = isaStrobes ? !readDirS : (readDirS && !strobeS_n);
  assign writeNow = isaStrobes ? !strobeS_n : (!readDirS && !strobeS_n);

  // address latch follows the bus while the address strobe is high
  logic [7:0] adAddr;
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      adAddr <= 8'h00;
    end else if (addrStrobeS) begin
      adAddr <= adS;
    end
  end

  // write data is held from inside the strobe, taken when it ends
  logic [7:0] wrData;
  logic       writePrev;
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      wrData    <= 8'h00;
      writePrev <= 1'b0;
    end else begin
      writePrev <= writeNow;
      if (writeNow) begin
        wrData <= adS;
      end
    end
  end

  // block match against the select pins, then bank and offset
  wire logic       blockMatch;
  wire logic       bankHit;
  wire logic [2:0] regOffset;
  wire logic       writeDone;
  assign blockMatch = adAddr[ircc_cfg_pkg::ADDR_BLOCK_MSB:ircc_cfg_pkg::ADDR_BLOCK_LSB]
                      == blockSelS;
  assign bankHit    = muxMode && !chipSelS_n && !addrEnableS && blockMatch &&
                      (adAddr[ircc_cfg_pkg::ADDR_BANK_MSB:ircc_cfg_pkg::ADDR_BANK_LSB]
                       == ircc_cfg_pkg::BANK_CONFIG);
  assign regOffset  = adAddr[2:0];
  assign writeDone  = writePrev && !writeNow && bankHit;

  // access state and index register
  ircc_cfg_pkg::cfg_state_t state;
  ircc_cfg_pkg::cfg_state_t next_state;
  logic [7:0]               cfgIndex;
  logic [7:0]               next_cfgIndex;

  wire logic inConfig;
  wire logic keyWrite;
  wire logic dataWrite;
  wire logic indexInRange;
  assign inConfig     = (state == ircc_cfg_pkg::ST_CONFIG);
  assign keyWrite     = writeDone && (regOffset == ircc_cfg_pkg::OFS_KEY_INDEX);
  assign dataWrite    = writeDone && (regOffset == ircc_cfg_pkg::OFS_DATA) && inConfig;
  assign indexInRange = (cfgIndex <= ircc_cfg_pkg::IDX_LAST);

  // key handling: run waits for entry, configuration loads index or exits
  always_comb begin
    next_state    = state;
    next_cfgIndex = cfgIndex;
    unique case (state)
      ircc_cfg_pkg::ST_RUN: begin
        if (keyWrite && (wrData == ircc_cfg_pkg::KEY_ENTER)) begin
          next_state = ircc_cfg_pkg::ST_CONFIG;
        end
      end
      ircc_cfg_pkg::ST_CONFIG: begin
        if (keyWrite && (wrData == ircc_cfg_pkg::KEY_EXIT)) begin
          next_state = ircc_cfg_pkg::ST_RUN;
        end else if (keyWrite) begin
          next_cfgIndex = wrData;
        end
      end
      default: begin
        next_state = ircc_cfg_pkg::ST_RUN;
      end
    endcase
  end

  // hard reset also leaves the configuration state; index keeps its byte
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state    <= ircc_cfg_pkg::ST_RUN;
      cfgIndex <= 8'h00;
    end else if (hardRstS) begin
      state    <= ircc_cfg_pkg::ST_RUN;
      cfgIndex <= cfgIndex;
    end else begin
      state    <= next_state;
      cfgIndex <= next_cfgIndex;
    end
  end

  // configuration registers
  logic [8*ircc_cfg_pkg::NUM_CFG_REGS-1:0] cfgRegs;
  wire  logic                               lockSet;
  wire  logic                               cfgWrEn;
  assign lockSet = cfgRegs[ircc_cfg_pkg::LOCK_BIT];
  assign cfgWrEn = dataWrite && indexInRange && !lockSet;

  cfg_reg_file #(
    .NUM_REGS (ircc_cfg_pkg::NUM_CFG_REGS)
  ) u_regs (
    .clk_sys   (clk_sys),
    .porRst_n  (rstSync_n),
    .hardReset (hardRstS),
    .wrEn      (cfgWrEn),
    .wrIndex   (cfgIndex[3:0]),
    .wrData    (wrData),
    .regsFlat  (cfgRegs)
  );

  // read selection: ports answer only in configuration, reserved offsets read zero
  wire logic [7:0] selReg;
  wire logic [7:0] next_adOut;
  wire logic       portRead;
  wire logic       next_adOe;
  assign selReg     = indexInRange ? cfgRegs[8*cfgIndex[3:0] +: 8] : 8'h00;
  assign portRead   = (regOffset == ircc_cfg_pkg::OFS_KEY_INDEX) ||
                      (regOffset == ircc_cfg_pkg::OFS_DATA);
  assign next_adOut = !inConfig ? 8'h00 :
                      (regOffset == ircc_cfg_pkg::OFS_KEY_INDEX) ? cfgIndex :
                      (regOffset == ircc_cfg_pkg::OFS_DATA) ? selReg : 8'h00;
  assign next_adOe  = readNow && bankHit && (inConfig || !portRead);

  // bus drive, interrupt polarity and status, all from flip-flops
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      adOut          <= 8'h00;
      adOe           <= 1'b0;
      irqPin         <= 1'b1;
      extraGpioAvail <= 1'b0;
      configActive   <= 1'b0;
      writeLocked    <= 1'b0;
    end else begin
      adOut          <= next_adOut;
      adOe           <= next_adOe;
      irqPin         <= irqRequest ^ !cfgRegs[ircc_cfg_pkg::IRQ_POL_BIT];
      extraGpioAvail <= muxMode;
      configActive   <= inConfig;
      writeLocked    <= lockSet;
    end
  end

  // chip select high never decodes
  property p_cs_idle;
    @(posedge clk_sys) disable iff (!rstSync_n)
    chipSelS_n |-> !bankHit;
  endproperty
  a_cs_idle: assert property (p_cs_idle)
    else $error("decode with chip select inactive");

  // mismatched block never decodes
  property p_block_miss;
    @(posedge clk_sys) disable iff (!rstSync_n)
    (adAddr[7:5] != blockSelS) |-> !bankHit;
  endproperty
  a_block_miss: assert property (p_block_miss)
    else $error("decode with block mismatch");

  // entry byte moves run to configuration on the next edge
  property p_enter;
    @(posedge clk_sys) disable iff (!rstSync_n || hardRstS)
    (state == ircc_cfg_pkg::ST_RUN && keyWrite && wrData == 8'h55)
      |=> (state == ircc_cfg_pkg::ST_CONFIG) && configActive == 1'b0 ##1 configActive;
  endproperty
  a_enter: assert property (p_enter)
    else $error("entry key not taken");

  // exit byte returns to run and leaves the index alone
  property p_exit;
    @(posedge clk_sys) disable iff (!rstSync_n || hardRstS)
    (inConfig && keyWrite && wrData == 8'haa)
      |=> (state == ircc_cfg_pkg::ST_RUN) && $stable(cfgIndex);
  endproperty
  a_exit: assert property (p_exit)
    else $error("exit key not taken");

  // any other offset-0 byte in configuration becomes the index
  property p_index_load;
    @(posedge clk_sys) disable iff (!rstSync_n || hardRstS)
    (inConfig && keyWrite && wrData != 8'haa)
      |=> inConfig && (cfgIndex == $past(wrData));
  endproperty
  a_index_load: assert property (p_index_load)
    else $error("index not loaded");

  // run state ignores every other key byte
  property p_run_ignore;
    @(posedge clk_sys) disable iff (!rstSync_n || hardRstS)
    (state == ircc_cfg_pkg::ST_RUN && keyWrite && wrData != 8'h55)
      |=> (state == ircc_cfg_pkg::ST_RUN) && $stable(cfgIndex);
  endproperty
  a_run_ignore: assert property (p_run_ignore)
    else $error("run state took a key");

  // access ports stay off the bus in run state
  property p_port_quiet;
    @(posedge clk_sys) disable iff (!rstSync_n)
    (readNow && bankHit && portRead && !inConfig) |=> !adOe;
  endproperty
  a_port_quiet: assert property (p_port_quiet)
    else $error("access port answered in run state");

  // interrupt pin follows request through the polarity bit
  property p_irq_pol;
    @(posedge clk_sys) disable iff (!rstSync_n)
    ##1 irqPin == ($past(irqRequest) ^ !$past(cfgRegs[0]));
  endproperty
  a_irq_pol: assert property (p_irq_pol)
    else $error("interrupt polarity wrong");

  // locked file ignores data port writes
  property p_locked;
    @(posedge clk_sys) disable iff (!rstSync_n || hardRstS)
    (lockSet && dataWrite) |=> $stable(cfgRegs);
  endproperty
  a_locked: assert property (p_locked)
    else $error("write reached locked registers");

  // extra gpio lines stay off in the isa mode (encoding 1)
  property p_gpio;
    @(posedge clk_sys) disable iff (!rstSync_n)
    (hostTypeS == 2'h1) |=> !extraGpioAvail;
  endproperty
  a_gpio: assert property (p_gpio)
    else $error("extra gpio in isa mode");

  // data port writes past the last index change nothing
  property p_index_range;
    @(posedge clk_sys) disable iff (!rstSync_n || hardRstS)
    (dataWrite && !indexInRange) |=> $stable(cfgRegs);
  endproperty
  a_index_range: assert property (p_index_range)
    else $error("write beyond last index reached a register");

  // reserved offsets answer with zero on the bus
  property p_reserved_read;
    @(posedge clk_sys) disable iff (!rstSync_n)
    (readNow && bankHit && (regOffset > ircc_cfg_pkg::OFS_DATA))
      |=> adOe && (adOut == 8'h00);
  endproperty
  a_reserved_read: assert property (p_reserved_read)
    else $error("reserved offset read not zero");

  // configuration state holds until the exit byte or hard reset
  property p_stay_config;
    @(posedge clk_sys) disable iff (!rstSync_n || hardRstS)
    (inConfig && !(keyWrite && (wrData == ircc_cfg_pkg::KEY_EXIT))) |=> inConfig;
  endproperty
  a_stay_config: assert property (p_stay_config)
    else $error("configuration state left without exit byte");

  // lock status output follows the lock bit one cycle late
  property p_lock_out;
    @(posedge clk_sys) disable iff (!rstSync_n)
    ##1 writeLocked == $past(lockSet);
  endproperty
  a_lock_out: assert property (p_lock_out)
    else $error("lock status output wrong");

endmodule : config_access_and_mux_decode
`default_nettype wire

//--- host_bus_model.sv
// host side model of the multiplexed address/data bus master
// assumes the bench resolves the shared data wire from the device enable
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
  input  wire logic       clk_sys,
  input  wire logic [1:0] host_type_select,
  input  wire logic [7:0] adOut,
  input  wire logic       adOe,
  output logic            addrEnable,
  output logic            addrStrobe,
  output logic            readDirPin,
  output logic            strobePin_n,
  output logic      [7:0] hostAd
);
  // idle bus; address enable never leaves low
  initial begin
    addrEnable  = 1'b0;
    addrStrobe  = 1'b0;
    readDirPin  = 1'b1;
    strobePin_n = 1'b1;
    hostAd      = 8'h00;
  end

  // one access, to any address in the bus range
  // pins pass two sync flops, so every phase lasts at least 3 clocks
  task automatic access(input logic [7:0] addr, input logic rd, input logic [7:0] wd,
                        output logic [7:0] rdata, output logic seen);
    @(posedge clk_sys);
    addrStrobe <= 1'b1;
    hostAd     <= addr;
    repeat (3) @(posedge clk_sys);
    addrStrobe <= 1'b0;
    repeat (3) @(posedge clk_sys);
    if (host_type_select == 2'h2) begin
      readDirPin  <= rd;
      strobePin_n <= 1'b0;
    end else if (rd) begin
      readDirPin <= 1'b0;
    end else begin
      strobePin_n <= 1'b0;
    end
    hostAd <= rd ? ~addr : wd; // released bus shows the inverse, not a stale value
    repeat (6) @(posedge clk_sys);
    rdata = adOut;
    seen  = adOe;
    readDirPin  <= 1'b1;
    strobePin_n <= 1'b1;
    hostAd      <= ~hostAd;
    repeat (6) @(posedge clk_sys);
  endtask : access
endmodule : host_bus_model
`default_nettype wire

//--- config_access_and_mux_decode_tb.sv
// self-checking bench for the configuration access and multiplexed decode block
// assumes block select pins at 1, so offsets 0, 1 and 2 sit at 20h, 21h, 22h
`timescale 1ns/100ps
`default_nettype none
module config_access_and_mux_decode_tb;
  logic       clk_sys;
  logic       rst_n;
  logic       hardReset;
  logic [1:0] host_type_select;
  logic [2:0] block_select_pins;
  logic       chip_sel_n;
  logic       irqRequest;
  logic       addrEnable;
  logic       addrStrobe;
  logic       readDirPin;
  logic       strobePin_n;
  logic [7:0] hostAd;
  logic [7:0] adIn;
  logic [7:0] adOut;
  logic       adOe;
  logic       irqPin;
  logic       extraGpioAvail;
  logic       configActive;
  logic       writeLocked;
  logic [7:0] rdv;
  logic       snv;
  int         badCount;
  int         cmpCount;
  localparam logic [7:0] POR [10] = '{8'h00, 8'h00, 8'h02, 8'h01, 8'h00,
                                      8'h00, 8'h00, 8'h03, 8'h00, 8'h00};

  // shared wire: device drives while its enable is high
  assign adIn = adOe ? adOut : hostAd;

  config_access_and_mux_decode config_access_and_mux_decode_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .hardReset(hardReset),
    .host_type_select(host_type_select), .block_select_pins(block_select_pins),
    .chip_sel_n(chip_sel_n), .addrEnable(addrEnable), .addrStrobe(addrStrobe),
    .readDirPin(readDirPin), .strobePin_n(strobePin_n), .adIn(adIn),
    .irqRequest(irqRequest), .adOut(adOut), .adOe(adOe), .irqPin(irqPin),
    .extraGpioAvail(extraGpioAvail), .configActive(configActive),
    .writeLocked(writeLocked));

  host_bus_model host_bus_model_inst (
    .clk_sys(clk_sys), .host_type_select(host_type_select), .adOut(adOut),
    .adOe(adOe), .addrEnable(addrEnable), .addrStrobe(addrStrobe),
    .readDirPin(readDirPin), .strobePin_n(strobePin_n), .hostAd(hostAd));

  // 40 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic testDone;
    $display("compares %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : testDone

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmpCount++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // bus helpers on top of the host model
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_bus_model_inst.access(a, 1'b0, d, rdv, snv);
  endtask : wr
  task automatic rdChk(input logic [7:0] a, input logic seen, input logic [7:0] d);
    host_bus_model_inst.access(a, 1'b1, 8'h00, rdv, snv);
    chk({7'h0, snv}, {7'h0, seen});
    if (seen) begin
      chk(rdv, d);
    end
  endtask : rdChk
  task automatic cfgWr(input logic [7:0] i, input logic [7:0] d);
    wr(8'h20, i);
    wr(8'h21, d);
  endtask : cfgWr
  task automatic cfgRd(input logic [7:0] i, input logic [7:0] d);
    wr(8'h20, i);
    rdChk(8'h21, 1'b1, d);
  endtask : cfgRd

  task automatic tRunState;
    chk({7'h0, configActive}, 8'h00);
    chk({7'h0, irqPin}, 8'h01);
    chk({7'h0, extraGpioAvail}, 8'h01);
    rdChk(8'h20, 1'b0, 8'h00);
    rdChk(8'h22, 1'b1, 8'h00);
    rdChk(8'h27, 1'b1, 8'h00);
  endtask : tRunState

  task automatic tEntry;
    wr(8'h20, 8'haa);
    chk({7'h0, configActive}, 8'h00);
    @(posedge clk_sys) chip_sel_n <= 1'b1;
    wr(8'h20, 8'h55);
    chk({7'h0, configActive}, 8'h00);
    @(posedge clk_sys) chip_sel_n <= 1'b0;
    wr(8'h00, 8'h55);
    chk({7'h0, configActive}, 8'h00);
    wr(8'h20, 8'h55);
    chk({7'h0, configActive}, 8'h01);
  endtask : tEntry

  task automatic tDefaults;
    for (int i = 0; i < 10; i++) begin
      cfgRd(8'(i), POR[i]);
    end
    wr(8'h20, 8'h07);
    rdChk(8'h20, 1'b1, 8'h07);
    cfgWr(8'h0a, 8'h3c);
    cfgRd(8'h0a, 8'h00);
  endtask : tDefaults

  task automatic tFields;
    cfgWr(8'h01, 8'hff);
    cfgRd(8'h01, 8'h03);
    cfgWr(8'h03, 8'hff);
    cfgRd(8'h03, 8'h11);
    cfgWr(8'h07, 8'h5a);
    cfgRd(8'h07, 8'h5a);
    cfgWr(8'h00, 8'h03);
    cfgRd(8'h00, 8'h01);
    chk({7'h0, irqPin}, 8'h00);
    @(posedge clk_sys) irqRequest <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk({7'h0, irqPin}, 8'h01);
    irqRequest <= 1'b0;
    wr(8'h20, 8'h55);
    rdChk(8'h20, 1'b1, 8'h55);
    chk({7'h0, configActive}, 8'h01);
  endtask : tFields

  task automatic tLockExit;
    cfgWr(8'h00, 8'h04);
    chk({7'h0, writeLocked}, 8'h01);
    cfgWr(8'h07, 8'h12);
    cfgRd(8'h07, 8'h5a);
    cfgWr(8'h00, 8'h00);
    cfgRd(8'h00, 8'h04);
    wr(8'h20, 8'haa);
    chk({7'h0, configActive}, 8'h00);
    rdChk(8'h21, 1'b0, 8'h00);
  endtask : tLockExit

  // hard reset clears registers 0 and 1 and keeps 7; then both other bus modes
  task automatic tHardReset;
    @(posedge clk_sys) hardReset <= 1'b1;
    repeat (4) @(posedge clk_sys);
    hardReset <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk({7'h0, writeLocked}, 8'h00);
    host_type_select <= 2'h2;
    wr(8'h20, 8'h55);
    chk({7'h0, configActive}, 8'h01);
    cfgRd(8'h00, 8'h00);
    cfgRd(8'h01, 8'h00);
    cfgRd(8'h07, 8'h5a);
    wr(8'h20, 8'haa);
    host_type_select <= 2'h1;
    repeat (6) @(posedge clk_sys);
    chk({7'h0, extraGpioAvail}, 8'h00);
    wr(8'h20, 8'h55);
    chk({7'h0, configActive}, 8'h00);
    host_type_select <= 2'h3;
  endtask : tHardReset

  task automatic tPowerOn;
    @(posedge clk_sys) rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    wr(8'h20, 8'h55);
    cfgRd(8'h07, 8'h03);
    cfgRd(8'h03, 8'h01);
  endtask : tPowerOn

  // main sequence
  initial begin
    badCount = 0;
    cmpCount = 0;
    rst_n = 1'b0;
    hardReset = 1'b0;
    host_type_select = 2'h3;
    block_select_pins = 3'h1;
    chip_sel_n = 1'b0;
    irqRequest = 1'b0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    tRunState();
    tEntry();
    tDefaults();
    tFields();
    tLockExit();
    tHardReset();
    tPowerOn();
    testDone();
  end

  // watchdog, far above the roughly 1500 cycles the run needs
  initial begin
    repeat (20000) @(posedge clk_sys);
    badCount++;
    testDone();
  end
endmodule : config_access_and_mux_decode_tb
`default_nettype wire
